// ===== osc_model.sv
// Behavioural clock source that settles some cycles after switch-on
`timescale 1ns/10ps
`default_nettype none
module osc_model #(
  parameter int READY_CYCLES = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Source control
  input wire logic src_enable,
  output logic osc_ready
);
  int count_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 0;
    end else if (!src_enable) begin
      // Stopped source loses stability at once
      count_reg <= 0;
    end else if (count_reg < READY_CYCLES) begin
      count_reg <= count_reg + 1;
    end
  end
  assign osc_ready = (count_reg >= READY_CYCLES);
endmodule
`default_nettype wire

// ===== sleep_ctrl_defs.svh
// Constants for the sleep-mode power controller
`ifndef SLEEP_CTRL_DEFS_SVH
`define SLEEP_CTRL_DEFS_SVH
`define OSC_SEL_W 2
`define OSC_SEL_PRI 2'h0
`define OSC_SEL_FRC 2'h1
`define OSC_SEL_LOW_POWER_INTERNAL_OSCILLATOR 2'h2
`define OSC_SEL_SEC 2'h3
`define WAKE_SRC_W 5
`define WAKE_SRC_CN 0
`define WAKE_SRC_WDOG 1
`define WAKE_SRC_ADC 2
`define WAKE_SRC_UART 3
`define WAKE_SRC_OWNCLK 4
`define START_US_PRI 1000
`define START_US_FRC 2
`define START_US_LOW_POWER_INTERNAL_OSCILLATOR 100
`define START_US_SEC 1000
`define CLOCK_MHZ 40
`define CNT_W 16
`endif

// ===== sleep_ctrl_pkg.sv
// Types for the sleep-mode power controller
package sleep_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_START = 4'h4,
    ST_RESUME = 4'h8
  } power_state_e;
endpackage

// ===== sleep_mode_power_control.sv
// Sleep-mode power controller: entry, hold and wake of the halted state
// Notes on behaviour
// - Sleep stops CPU and most peripherals.
// - System clock source off unless overridden.
// - Wake delay depends on selected oscillator.
// - Fail-safe clock monitor suspended in sleep.
// - Brown-out detector stays enabled in sleep.
// - Watchdog not cleared on sleep entry.
// - Selected peripherals keep running in sleep.
// - Wake request from running peripheral resumes.
// - Port pin drive held unchanged during sleep.
// - USB may keep primary or fast oscillator.
// - System-clocked peripherals halted, own-clock ones run.
`timescale 1ns/10ps
`default_nettype none
`include "sleep_ctrl_defs.svh"
module sleep_mode_power_control
  import sleep_ctrl_pkg::*;
#(
  parameter int PINS = 16,
  parameter int CNT_W = `CNT_W,
  parameter int CLOCK_MHZ = `CLOCK_MHZ,
  parameter int START_US_PRI = `START_US_PRI,
  parameter int START_US_FRC = `START_US_FRC,
  parameter int START_US_LOW_POWER_INTERNAL_OSCILLATOR = `START_US_LOW_POWER_INTERNAL_OSCILLATOR,
  parameter int START_US_SEC = `START_US_SEC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // CPU side
  input wire logic sleep_req,
  output logic cpu_halt,
  // Clock source control
  input wire logic [`OSC_SEL_W-1:0] osc_select,
  input wire logic osc_ready,
  input wire logic usb_keep_pri,
  input wire logic usb_keep_frc,
  output logic sysclk_src_enable,
  output logic sysclk_gate_enable,
  // Safety functions
  input wire logic wdog_enable,
  output logic fail_safe_clock_monitor_enable,
  output logic brownout_reset_detector_enable,
  output logic watchdog_timer_clear,
  output logic watchdog_timer_run,
  // Peripherals and wake sources
  input wire logic [`WAKE_SRC_W-1:0] module_enable,
  input wire logic [`WAKE_SRC_W-1:0] wake_req,
  output logic [`WAKE_SRC_W-1:0] sleep_run_enable,
  output logic [`WAKE_SRC_W-1:0] wake_source,
  // Port pins
  input wire logic [PINS-1:0] pin_out_core,
  input wire logic [PINS-1:0] pin_oe_n_core,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n,
  // Status
  output logic in_sleep
);

  ////////////////////////////////////////////////////////////////////////////
  // Start-up counts: microseconds times clock MHz, truncated to CNT_W bits
  function automatic logic [CNT_W-1:0] us_to_cycles(input int us);
    us_to_cycles = CNT_W'(us * CLOCK_MHZ);
  endfunction

  localparam logic [CNT_W-1:0] CYC_PRI = us_to_cycles(START_US_PRI);
  localparam logic [CNT_W-1:0] CYC_FRC = us_to_cycles(START_US_FRC);
  localparam logic [CNT_W-1:0] CYC_LOW_POWER_INTERNAL_OSCILLATOR = us_to_cycles(START_US_LOW_POWER_INTERNAL_OSCILLATOR);
  localparam logic [CNT_W-1:0] CYC_SEC = us_to_cycles(START_US_SEC);

  function automatic logic [CNT_W-1:0] start_cycles(input logic [`OSC_SEL_W-1:0] sel);
    unique case (sel)
      `OSC_SEL_PRI: start_cycles = CYC_PRI;
      `OSC_SEL_FRC: start_cycles = CYC_FRC;
      `OSC_SEL_LOW_POWER_INTERNAL_OSCILLATOR: start_cycles = CYC_LOW_POWER_INTERNAL_OSCILLATOR;
      default: start_cycles = CYC_SEC;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    power_state_e state;
    logic cpu_halt;
    logic src_en;
    logic gate_en;
    logic fail_safe_clock_monitor_en;
    logic wdog_clear;
    logic [`WAKE_SRC_W-1:0] run_en;
    logic [`WAKE_SRC_W-1:0] wake_src;
    logic [PINS-1:0] pin_out;
    logic [PINS-1:0] pin_oe_n;
    logic load;
    logic bor_en;
    logic wdog_run;
    logic sleeping;
  } ctrl_s;

  ctrl_s ctrl_reg;
  ctrl_s ctrl_next;
  logic delay_done;
  logic usb_hold;
  logic [`WAKE_SRC_W-1:0] wake_hit;

  // Only modules left enabled by software can run or wake the part
  assign wake_hit = wake_req & module_enable;
  // USB override applies only to the source it can hold
  assign usb_hold = (usb_keep_pri && osc_select == `OSC_SEL_PRI) ||
                    (usb_keep_frc && osc_select == `OSC_SEL_FRC);

  wake_delay_counter #(
    .CNT_W(CNT_W)
  ) u_delay (
    .clock(clock),
    .resetn(resetn),
    .load(ctrl_reg.load),
    .load_value(start_cycles(osc_select)),
    .osc_ready(osc_ready),
    .done(delay_done)
  );

  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl_next.load = 1'b0;
    ctrl_next.wdog_clear = 1'b0;
    // Detector never gated by the sequencer
    ctrl_next.bor_en = 1'b1;
    // Watchdog keeps counting from its present value in sleep
    ctrl_next.wdog_run = wdog_enable;
    unique case (ctrl_reg.state)
      ST_RUN: begin
        ctrl_next.pin_out = pin_out_core;
        ctrl_next.pin_oe_n = pin_oe_n_core;
        ctrl_next.run_en = module_enable;
        if (sleep_req) begin
          ctrl_next.state = ST_SLEEP;
          ctrl_next.cpu_halt = 1'b1;
          ctrl_next.gate_en = 1'b0;
          ctrl_next.src_en = usb_hold;
          ctrl_next.fail_safe_clock_monitor_en = 1'b0;
          ctrl_next.wake_src = '0;
        end
      end
      ST_SLEEP: begin
        ctrl_next.src_en = usb_hold;
        if (wake_hit != '0) begin
          ctrl_next.state = ST_START;
          ctrl_next.wake_src = wake_hit;
          ctrl_next.src_en = 1'b1;
          ctrl_next.load = 1'b1;
        end
      end
      ST_START: begin
        if (delay_done) begin
          ctrl_next.state = ST_RESUME;
          ctrl_next.gate_en = 1'b1;
        end
      end
      ST_RESUME: begin
        ctrl_next.state = ST_RUN;
        ctrl_next.cpu_halt = 1'b0;
        ctrl_next.fail_safe_clock_monitor_en = 1'b1;
      end
      default: begin
        ctrl_next.state = ST_RUN;
      end
    endcase
    ctrl_next.sleeping = ctrl_next.state == ST_SLEEP;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg.state <= ST_RUN;
      ctrl_reg.cpu_halt <= 1'b0;
      ctrl_reg.src_en <= 1'b1;
      ctrl_reg.gate_en <= 1'b1;
      ctrl_reg.fail_safe_clock_monitor_en <= 1'b1;
      ctrl_reg.wdog_clear <= 1'b0;
      ctrl_reg.run_en <= '0;
      ctrl_reg.wake_src <= '0;
      ctrl_reg.pin_out <= '0;
      ctrl_reg.pin_oe_n <= '1;
      ctrl_reg.load <= 1'b0;
      ctrl_reg.bor_en <= 1'b1;
      ctrl_reg.wdog_run <= 1'b0;
      ctrl_reg.sleeping <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cpu_halt = ctrl_reg.cpu_halt;
  assign sysclk_src_enable = ctrl_reg.src_en;
  assign sysclk_gate_enable = ctrl_reg.gate_en;
  assign fail_safe_clock_monitor_enable = ctrl_reg.fail_safe_clock_monitor_en;
  assign brownout_reset_detector_enable = ctrl_reg.bor_en;
  assign watchdog_timer_clear = ctrl_reg.wdog_clear;
  assign watchdog_timer_run = ctrl_reg.wdog_run;
  // Run enables frozen at entry; these units use their own clocks
  assign sleep_run_enable = ctrl_reg.run_en;
  assign wake_source = ctrl_reg.wake_src;
  // Pin drive latched at entry, held until the CPU resumes
  assign pin_out = ctrl_reg.pin_out;
  assign pin_oe_n = ctrl_reg.pin_oe_n;
  assign in_sleep = ctrl_reg.sleeping;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_entry_halts: assert property (@(posedge clock) disable iff (!resetn)
    ctrl_reg.state == ST_RUN && sleep_req |=> cpu_halt && !sysclk_gate_enable)
    else $error("sleep entry did not halt CPU and clock");
  a_src_off: assert property (@(posedge clock) disable iff (!resetn)
    in_sleep && !usb_keep_pri && !usb_keep_frc |-> !sysclk_src_enable)
    else $error("clock source running in sleep without override");
  a_fail_safe_clock_monitor_off: assert property (@(posedge clock) disable iff (!resetn)
    in_sleep |-> !fail_safe_clock_monitor_enable)
    else $error("clock monitor active in sleep");
  a_bor_on: assert property (@(posedge clock) disable iff (!resetn)
    in_sleep |-> brownout_reset_detector_enable)
    else $error("brown-out detector off in sleep");
  a_wdog_kept: assert property (@(posedge clock) disable iff (!resetn)
    $rose(cpu_halt) |-> !watchdog_timer_clear)
    else $error("watchdog cleared on sleep entry");
  a_wake_start: assert property (@(posedge clock) disable iff (!resetn)
    in_sleep && (wake_req & module_enable) != '0 |=> ctrl_reg.state == ST_START && sysclk_src_enable)
    else $error("wake request ignored");
  a_pins_held: assert property (@(posedge clock) disable iff (!resetn)
    in_sleep ##1 in_sleep |-> $stable(pin_out) && $stable(pin_oe_n))
    else $error("pin drive changed in sleep");
  a_usb_hold: assert property (@(posedge clock) disable iff (!resetn)
    in_sleep ##1 in_sleep && $past(usb_keep_frc) && $past(osc_select) == `OSC_SEL_FRC |-> sysclk_src_enable)
    else $error("USB override not honoured");
  a_resume: assert property (@(posedge clock) disable iff (!resetn)
    ctrl_reg.state == ST_START && delay_done |=> sysclk_gate_enable ##1 !cpu_halt)
    else $error("resume sequence wrong");
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the sleep-mode power controller
`timescale 1ns/10ps
`default_nettype none
`include "sleep_ctrl_defs.svh"
module tb;
  localparam int MHZ = 40;
  localparam int US_PRI = 2;
  localparam int US_FRC = 1;
  localparam int US_LOW_POWER_INTERNAL_OSCILLATOR = 3;
  localparam int US_SEC = 4;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic sleep_req = 1'b0;
  logic [`OSC_SEL_W-1:0] osc_select = `OSC_SEL_PRI;
  logic osc_ready;
  logic usb_keep_pri = 1'b0;
  logic usb_keep_frc = 1'b0;
  logic wdog_enable = 1'b0;
  logic [`WAKE_SRC_W-1:0] module_enable = 5'h00;
  logic [`WAKE_SRC_W-1:0] wake_req = 5'h00;
  logic [15:0] pin_out_core = 16'h0000;
  logic [15:0] pin_oe_n_core = 16'hffff;
  logic cpu_halt, src_en, gate_en, fail_safe_clock_monitor_en, bor_en, wdt_clear, wdt_run, in_sleep;
  logic [`WAKE_SRC_W-1:0] run_en, wake_src;
  logic [15:0] pin_out, pin_oe_n;
  int bad_count = 0;
  int comparisons = 0;

  always #12.5 clock = ~clock;

  sleep_mode_power_control #(.PINS(16), .START_US_PRI(US_PRI), .START_US_FRC(US_FRC),
    .START_US_LOW_POWER_INTERNAL_OSCILLATOR(US_LOW_POWER_INTERNAL_OSCILLATOR), .START_US_SEC(US_SEC)) i_dut (
    .clock(clock), .resetn(resetn), .sleep_req(sleep_req), .cpu_halt(cpu_halt),
    .osc_select(osc_select), .osc_ready(osc_ready), .usb_keep_pri(usb_keep_pri),
    .usb_keep_frc(usb_keep_frc), .sysclk_src_enable(src_en), .sysclk_gate_enable(gate_en),
    .wdog_enable(wdog_enable), .fail_safe_clock_monitor_enable(fail_safe_clock_monitor_en),
    .brownout_reset_detector_enable(bor_en), .watchdog_timer_clear(wdt_clear),
    .watchdog_timer_run(wdt_run), .module_enable(module_enable), .wake_req(wake_req),
    .sleep_run_enable(run_en), .wake_source(wake_src), .pin_out_core(pin_out_core),
    .pin_oe_n_core(pin_oe_n_core), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .in_sleep(in_sleep));

  osc_model #(.READY_CYCLES(10)) i_osc (.clock(clock), .resetn(resetn), .src_enable(src_en),
    .osc_ready(osc_ready));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check_reset();
    chk(16'(cpu_halt), 16'h0);
    chk(16'(src_en), 16'h1);
    chk(16'(gate_en), 16'h1);
    chk(16'(fail_safe_clock_monitor_en), 16'h1);
    chk(16'(in_sleep), 16'h0);
    chk(pin_oe_n, 16'hffff);
  endtask

  task automatic enter_sleep(input logic [1:0] sel, input logic kp, input logic kf,
                             input logic [4:0] en, input logic exp_src);
    @(negedge clock);
    osc_select = sel;
    usb_keep_pri = kp;
    usb_keep_frc = kf;
    module_enable = en;
    wdog_enable = en[`WAKE_SRC_WDOG];
    pin_out_core = 16'ha5c3;
    pin_oe_n_core = 16'h0f0f;
    sleep_req = 1'b1;
    @(negedge clock);
    sleep_req = 1'b0;
    chk(16'(cpu_halt), 16'h1);
    chk(16'(in_sleep), 16'h1);
    chk(16'(gate_en), 16'h0);
    chk(16'(fail_safe_clock_monitor_en), 16'h0);
    chk(16'(bor_en), 16'h1);
    chk(16'(src_en), 16'(exp_src));
    chk(16'(wdt_clear), 16'h0);
    chk(16'(wdt_run), 16'(en[`WAKE_SRC_WDOG]));
    chk(16'(run_en), 16'(en));
    pin_out_core = 16'h5a3c;
    pin_oe_n_core = 16'hf0f0;
    @(negedge clock);
    chk(pin_out, 16'ha5c3);
    chk(pin_oe_n, 16'h0f0f);
  endtask

  // Requests from disabled modules and a repeated sleep command must not wake
  task automatic refused_wake();
    wake_req = ~module_enable;
    sleep_req = 1'b1;
    repeat (4) @(negedge clock);
    wake_req = 5'h00;
    sleep_req = 1'b0;
    chk(16'(in_sleep), 16'h1);
    chk(16'(cpu_halt), 16'h1);
  endtask

  task automatic wake_up(input int b, input int n);
    int cyc;
    cyc = 0;
    @(negedge clock);
    wake_req = 5'(1 << b);
    while (cpu_halt !== 1'b0 && cyc < 2000) begin
      @(negedge clock);
      cyc++;
      if (cyc == 2) begin
        chk(16'(src_en), 16'h1);
        chk(16'(cpu_halt), 16'h1);
        chk(pin_out, 16'ha5c3);
      end
    end
    wake_req = 5'h00;
    if (cyc >= 2000) begin
      bad_count++;
      report_and_stop();
    end
    // Window allows for load and gating edges around the count
    chk(16'(cyc >= n + 1 && cyc <= n + 8), 16'h1);
    chk(16'(wake_src), 16'(1 << b));
    chk(16'(gate_en), 16'h1);
    chk(16'(fail_safe_clock_monitor_en), 16'h1);
    chk(16'(in_sleep), 16'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    check_reset();
    enter_sleep(`OSC_SEL_PRI, 1'b0, 1'b0, 5'h01, 1'b0);
    refused_wake();
    wake_up(`WAKE_SRC_CN, US_PRI * MHZ);
    enter_sleep(`OSC_SEL_FRC, 1'b0, 1'b1, 5'h02, 1'b1);
    wake_up(`WAKE_SRC_WDOG, US_FRC * MHZ);
    enter_sleep(`OSC_SEL_LOW_POWER_INTERNAL_OSCILLATOR, 1'b1, 1'b0, 5'h04, 1'b0);
    wake_up(`WAKE_SRC_ADC, US_LOW_POWER_INTERNAL_OSCILLATOR * MHZ);
    enter_sleep(`OSC_SEL_SEC, 1'b0, 1'b0, 5'h08, 1'b0);
    wake_up(`WAKE_SRC_UART, US_SEC * MHZ);
    enter_sleep(`OSC_SEL_PRI, 1'b1, 1'b0, 5'h1f, 1'b1);
    wake_up(`WAKE_SRC_OWNCLK, US_PRI * MHZ);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== wake_delay_counter.sv
// Oscillator start-up delay counter used on the way out of sleep
`timescale 1ns/10ps
`default_nettype none
`include "sleep_ctrl_defs.svh"
module wake_delay_counter #(
  parameter int CNT_W = `CNT_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic osc_ready,
  // Status
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic busy;
  } cnt_s;

  cnt_s cnt_reg;
  cnt_s cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next.count = load_value;
      cnt_next.busy = 1'b1;
    end else if (cnt_reg.busy && cnt_reg.count != '0) begin
      cnt_next.count = cnt_reg.count - 1'b1;
    end
    if (!load && cnt_reg.busy && cnt_reg.count == '0 && osc_ready) begin
      cnt_next.busy = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Oscillator must also report stable; the count alone is only a floor
  assign done = cnt_reg.busy && cnt_reg.count == '0 && osc_ready && !load;
endmodule
`default_nettype wire
